// ### smrd_regs.svh
`ifndef SMRD_REGS_SVH
`define SMRD_REGS_SVH

// Parameter offsets of the descriptors held here
`define SMRD_OFS_HDR 8'h62
`define SMRD_OFS_RGN1 8'h68
`define SMRD_OFS_RGN2 8'h6C
`define SMRD_DESC_BYTES 8'h04

// Size field coding
`define SMRD_SIZE_UNIT 32'd256
`define SMRD_SIZE_LSB 8
`define SMRD_RGN1_BYTES 32'd32768
`define SMRD_SECT64_BYTES 32'd65536
`define SMRD_RGN2_SECT_128 32'd255
`define SMRD_RGN2_SECT_256 32'd511

// Header fields
`define SMRD_HDR_RFU 8'hFF
`define SMRD_HDR_RGN_COUNT 8'h02
`define SMRD_CFG_ID 8'h00
`define SMRD_HDR_LOW 8'hFE

// Erase-support byte fields
`define SMRD_ERASE_RFU 4'hF
`define SMRD_ERASE_T4 1'h0
`define SMRD_ERASE_T3 1'h0
`define SMRD_ERASE_T2 1'h1
`define SMRD_ERASE_T1 1'h0

// Descriptor slots of the byte table
`define SMRD_NUM_DESC 3
`define SMRD_SLOT_HDR 0
`define SMRD_SLOT_RGN1 1
`define SMRD_SLOT_RGN2 2

// Register values after reset
`define SMRD_CNT_RESET 2'h0
`define SMRD_DATA_RESET 8'h00

// Answer for offsets outside the table
`define SMRD_BLANK 8'hFF

// Cycles that the strap synchroniser needs before it is trusted
`define SMRD_SETTLE 2'h2

`endif

// ### smrd_pkg.sv
package smrd_pkg;

    typedef enum logic [1:0] {
        SMRD_SETTLE_ST = 2'b01,
        SMRD_READY_ST = 2'b10
    } smrd_state_t;

    typedef struct packed {
        smrd_state_t state;
        logic [1:0] cnt;
        logic dens_256;
        logic [7:0] rd_data;
        logic rd_valid;
    } smrd_regs_t;

endpackage

// ### smrd_sync.sv
module smrd_sync (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Level from outside the clock domain
    input wire logic async_in,
    output logic sync_out
);

    logic meta_q;
    logic sync_q;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// ### smrd_rom.sv
// How it works
// R1: Size field is 256-byte unit count minus one
// R2: Offset 68h region size reads 00007Fh
// R3: 32KB region erase byte F2h, 64KB only
// R4: 128Mb third region size reads 00FEFFh
// R5: 256Mb size 01FEFFh; byte 6Fh 01h/00h
// R6: Remainder region erase byte 64KB only, ones
// R7: Configuration header carries identifier 00h
// R8: Descriptors returned low byte first, ascending
`include "smrd_regs.svh"

module smrd_rom (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Density strap pin, high for the 256Mb part
    input wire logic dens_256_pin,
    // Byte read port
    input wire logic rd_req,
    input wire logic [7:0] rd_addr,
    output logic rd_ready,
    output logic [7:0] rd_data,
    output logic rd_valid
);

    ////////////////////////////////////////////////////////////////////////
    // Descriptor field coding

    // Size fields count 256-byte units, stored one less than the count
    function automatic logic [23:0] size_field(input logic [31:0] bytes);
        logic [31:0] units;
        units = bytes / `SMRD_SIZE_UNIT;
        size_field = 24'(units - 32'd1); // see R1
    endfunction

    function automatic logic [7:0] erase_byte();
        // Ones in the reserved nibble, only the 64KB erase type set
        erase_byte = {
            `SMRD_ERASE_RFU,
            `SMRD_ERASE_T4,
            `SMRD_ERASE_T3,
            `SMRD_ERASE_T2,
            `SMRD_ERASE_T1
        }; // see R3 see R6
    endfunction

    function automatic logic [7:0] pick(input logic [31:0] word, input logic [1:0] idx);
        // Lowest offset carries the least significant byte
        case (idx) // see R8
            2'h0: pick = word[7:0];
            2'h1: pick = word[15:8];
            2'h2: pick = word[23:16];
            2'h3: pick = word[31:24];
            default: pick = word[7:0];
        endcase
    endfunction

    // True when the offset lies inside the four bytes from base
    function automatic logic in_desc(input logic [7:0] addr, input logic [7:0] base);
        in_desc = (addr >= base) && (addr < 8'(base + `SMRD_DESC_BYTES));
    endfunction

    // First parameter offset of each descriptor slot
    // An unknown slot gets a base that no offset can fall inside
    function automatic logic [7:0] desc_base(input int unsigned slot);
        case (slot)
            `SMRD_SLOT_HDR: desc_base = `SMRD_OFS_HDR;
            `SMRD_SLOT_RGN1: desc_base = `SMRD_OFS_RGN1;
            `SMRD_SLOT_RGN2: desc_base = `SMRD_OFS_RGN2;
            default: desc_base = `SMRD_BLANK;
        endcase
    endfunction

    // Reads are taken only once the strap has been caught
    function automatic logic is_ready(input smrd_pkg::smrd_state_t st);
        is_ready = (st == smrd_pkg::SMRD_READY_ST);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Strap synchroniser

    // The strap is a pin level with no relation to ref_clk
    logic dens_sync;

    smrd_sync u_sync (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in(dens_256_pin),
        .sync_out(dens_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // State

    smrd_pkg::smrd_regs_t r_q;
    smrd_pkg::smrd_regs_t r_d;

    ////////////////////////////////////////////////////////////////////////
    // Descriptor words

    logic [31:0] rgn2_sect;
    logic [31:0] desc_w [`SMRD_NUM_DESC];

    // The header and second region are fixed; the third region grows
    // with the density caught after reset
    always_comb begin
        rgn2_sect = r_q.dens_256 ? `SMRD_RGN2_SECT_256 : `SMRD_RGN2_SECT_128; // see R4 see R5
        desc_w[`SMRD_SLOT_HDR] = {
            `SMRD_HDR_RFU,
            `SMRD_HDR_RGN_COUNT,
            `SMRD_CFG_ID, // see R7
            `SMRD_HDR_LOW
        };
        desc_w[`SMRD_SLOT_RGN1] = {
            size_field(`SMRD_RGN1_BYTES), // see R2
            erase_byte() // see R3
        };
        desc_w[`SMRD_SLOT_RGN2] = {
            size_field(rgn2_sect * `SMRD_SECT64_BYTES), // see R4 see R5
            erase_byte() // see R6
        };
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte table

    // Pure wiring: the table costs no flip-flops
    logic [7:0] desc_byte [`SMRD_NUM_DESC][`SMRD_DESC_BYTES];

    // Lowest offset of each descriptor carries its least significant byte
    generate
        for (genvar gd = 0; gd < `SMRD_NUM_DESC; gd++) begin : g_desc
            for (genvar gb = 0; gb < `SMRD_DESC_BYTES; gb++) begin : g_byte
                assign desc_byte[gd][gb] = pick(desc_w[gd], 2'(gb)); // see R8
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Offset decode

    logic [`SMRD_NUM_DESC-1:0] addr_hit;
    logic [7:0] rom_out;

    // One hit bit per descriptor slot
    always_comb begin
        for (int n = 0; n < `SMRD_NUM_DESC; n++) begin
            addr_hit[n] = in_desc(rd_addr, desc_base(n));
        end
    end

    // Descriptors never overlap, so at most one slot claims an offset;
    // offsets outside every slot read as blank
    always_comb begin
        logic [7:0] ofs;
        ofs = 8'h00;
        rom_out = `SMRD_BLANK;
        for (int n = 0; n < `SMRD_NUM_DESC; n++) begin
            if (addr_hit[n]) begin
                ofs = 8'(rd_addr - desc_base(n));
                rom_out = desc_byte[n][ofs[1:0]];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read sequencing

    logic rd_take;

    // Requests before the strap is caught are dropped with no answer
    assign rd_take = rd_req && is_ready(r_q.state);

    always_comb begin
        r_d = r_q;
        // A new byte is flagged for exactly one cycle
        r_d.rd_valid = 1'b0;
        case (r_q.state)
            smrd_pkg::SMRD_SETTLE_ST: begin
                // Density is caught once the synchroniser has filled
                if (r_q.cnt == `SMRD_SETTLE) begin
                    r_d.dens_256 = dens_sync;
                    r_d.state = smrd_pkg::SMRD_READY_ST;
                end else begin
                    r_d.cnt = 2'(r_q.cnt + 2'h1);
                end
            end
            smrd_pkg::SMRD_READY_ST: begin
                // Data holds its last value between reads
                if (rd_take) begin
                    r_d.rd_data = rom_out;
                    r_d.rd_valid = 1'b1;
                end
            end
            default: begin
                // Any illegal code falls back to a fresh strap capture
                r_d.state = smrd_pkg::SMRD_SETTLE_ST;
                r_d.cnt = `SMRD_CNT_RESET;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            r_q.state <= smrd_pkg::SMRD_SETTLE_ST;
            r_q.cnt <= `SMRD_CNT_RESET;
            r_q.dens_256 <= 1'b0;
            r_q.rd_data <= `SMRD_DATA_RESET;
            r_q.rd_valid <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Ready is a level from the state register, data and valid are flops
    assign rd_ready = is_ready(r_q.state);
    assign rd_data = r_q.rd_data;
    assign rd_valid = r_q.rd_valid;

endmodule

// ### smrd_rom_assertions.sv
module smrd_rom_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Strap and read port
    input wire logic dens_256_pin,
    input wire logic rd_req,
    input wire logic [7:0] rd_addr,
    input wire logic rd_ready,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    wire tk = rd_req && rd_ready;
    idle_quiet_a: assert property (!tk |=> !rd_valid) else $error("stray valid");
    answer_next_a: assert property (tk |=> rd_valid) else $error("missing valid");
    rgn1_erase_a: assert property (tk && rd_addr == 8'h68 |=> rd_valid && rd_data == 8'hF2)
        else $error("bad 68h");
    rgn1_size_a: assert property (tk && rd_addr == 8'h69 |=> rd_data == 8'h7F)
        else $error("bad 69h");
    rgn1_high_a: assert property (tk && rd_addr == 8'h6B |=> rd_data == 8'h00)
        else $error("bad 6Bh");
    rgn2_erase_a: assert property (tk && rd_addr == 8'h6C |=> rd_data == 8'hF2)
        else $error("bad 6Ch");
    rgn2_low_a: assert property (tk && rd_addr == 8'h6D |=> rd_data == 8'hFF)
        else $error("bad 6Dh");
    rgn2_mid_a: assert property (tk && rd_addr == 8'h6E |=> rd_data == 8'hFE)
        else $error("bad 6Eh");
    rgn2_top_a: assert property (tk && rd_addr == 8'h6F |=> rd_data == {7'h00, dens_256_pin})
        else $error("bad 6Fh");
    cfg_id_a: assert property (tk && rd_addr == 8'h63 |=> rd_data == 8'h00)
        else $error("bad 63h");
endmodule

// ### smrd_host.sv
module smrd_host (
    // Clock
    input wire logic ref_clk,
    // Read port
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    output logic rd_req,
    output logic [7:0] rd_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rd_req = 1'b0;
    initial rd_addr = 8'h00;
    // Four back-to-back byte reads, assembled low byte first
    task automatic read_word(input logic [7:0] base, output logic [31:0] w);
        w = 32'h0;
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            rd_req <= i < 4;
            rd_addr <= i < 4 ? base + 8'(i) : ~rd_addr;
            @(negedge ref_clk);
            if (rd_valid === 1'b1) w = {rd_data, w[31:8]};
        end
    endtask
endmodule

// ### tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic dens = 1'b0;
    logic rd_req, rd_ready, rd_valid;
    logic [7:0] rd_addr, rd_data;
    logic [31:0] w;
    int miscompares = 0;
    int n_tests = 0;
    always #12.5 ref_clk = ~ref_clk;
    smrd_rom dut (.ref_clk(ref_clk), .reset_n(reset_n), .dens_256_pin(dens), .rd_req(rd_req),
        .rd_addr(rd_addr), .rd_ready(rd_ready), .rd_data(rd_data), .rd_valid(rd_valid));
    smrd_host host (.ref_clk(ref_clk), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_req(rd_req), .rd_addr(rd_addr));
    function automatic logic [7:0] exp_byte(logic [7:0] a, logic d);
        logic [31:0] s1, s2;
        s1 = 32768 / 256 - 1;
        s2 = (d ? 511 : 255) * 65536 / 256 - 1;
        case (a)
            8'h62: return 8'hFE;
            8'h63: return 8'h00;
            8'h64: return 8'h02;
            8'h68, 8'h6C: return 8'hF2;
            8'h69: return s1[7:0];
            8'h6A: return s1[15:8];
            8'h6B: return s1[23:16];
            8'h6D: return s2[7:0];
            8'h6E: return s2[15:8];
            8'h6F: return s2[23:16];
            default: return 8'hFF;
        endcase
    endfunction
    function automatic logic [31:0] exp_word(logic [7:0] b, logic d);
        logic [7:0] q[$];
        for (int i = 0; i < 4; i++) q.push_back(exp_byte(b + 8'(i), d));
        exp_word = 32'h0;
        while (q.size() > 0) exp_word = {q.pop_front(), exp_word[31:8]};
    endfunction
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task print_verdict;
        $display("counts: %0d compared, %0d wrong", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        #50us;
        miscompares++;
        print_verdict();
    end
    initial begin
        logic [7:0] b;
        void'($urandom(17138));
        for (int d = 0; d < 2; d++) begin
            @(posedge ref_clk);
            reset_n <= 1'b0;
            dens <= d[0];
            repeat (2) @(posedge ref_clk);
            reset_n <= 1'b1;
            repeat (5) @(negedge ref_clk);
            cmp({31'h0, rd_ready}, 32'h1);
            for (int k = 0; k < 24; k++) begin
                b = k < 5 ? 8'h60 + 8'(k * 4) : 8'h60 + 8'($urandom % 24);
                host.read_word(b, w);
                cmp(w, exp_word(b, d[0]));
            end
            $display("test density %0d done", d);
        end
        print_verdict();
    end
endmodule
bind smrd_rom smrd_rom_assertions chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .dens_256_pin(dens_256_pin), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
    .rd_data(rd_data), .rd_valid(rd_valid));
